// ===== bfs_breaker_model.sv
// Purpose: Monitored breaker: position contacts and the current through it.
// Assumes: Single clock pclk, asynchronous active-low reset.
// Notes: Contacts and current work or stick independently.
module bfs_breaker_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic trip_cmd,
    input wire logic pos_works,
    input wire logic cur_works,
    input wire logic [15:0] load_current,
    output logic breaker_open,
    output logic [15:0] current
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] age;

    // The breaker recloses once the trip command drops, so every case
    // starts from a closed, loaded breaker.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            age <= 4'h0;
        else if (!trip_cmd)
            age <= 4'h0;
        else if (age != 4'hf)
            age <= age + 4'h1;
    end

    // Opening takes six clocks, so it lands after the start tick.
    assign breaker_open = pos_works && (age >= 4'h6);
    assign current = (cur_works && (age >= 4'h6)) ? 16'h0000 : load_current;
endmodule

// ===== bfs_pkg.sv
// Purpose: Shared constants for the breaker failure supervision block.
// Assumes: APB with 32-bit data and an 8-bit byte address.
// Notes: Every offset; control, set and interrupt fields; the configuration reset values; the tick base.
package bfs_pkg;

    // Time base: the supervision timer counts ticks of this period.
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TICK_PERIOD_NS = 1000;
    localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_ACTIVE = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
    localparam logic [7:0] ADDR_ACK = 8'h14;
    localparam logic [7:0] ADDR_SET_BASE = 8'h20;
    localparam logic [7:0] ADDR_SET_MASK = 8'hf0;

    // Control register fields.
    localparam int unsigned CTRL_METHOD_LSB = 0;
    localparam int unsigned CTRL_INSEL_BIT = 2;
    localparam int unsigned CTRL_WIDEF_BIT = 3;
    localparam logic [1:0] CTRL_METHOD_RESET = 2'h0;
    localparam logic CTRL_INSEL_RESET = 1'b1;
    localparam logic CTRL_WIDEF_RESET = 1'b0;

    // Failure detection methods.
    localparam logic [1:0] METHOD_CURRENT = 2'h0;
    localparam logic [1:0] METHOD_POSITION = 2'h1;
    localparam logic [1:0] METHOD_COMBINED = 2'h2;

    // Parameter sets: four words, time in the low half, threshold high.
    localparam int unsigned SET_COUNT = 4;
    localparam int unsigned SET_TIME_LSB = 0;
    localparam int unsigned SET_THR_LSB = 16;
    localparam int unsigned SET_FIELD_W = 16;
    localparam logic [31:0] SET_RESET = 32'h0100_0064;
    localparam logic [1:0] ACTIVE_RESET = 2'h0;

    // Interrupt status and mask bits.
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_TRIP = 0;
    localparam int unsigned IRQ_REJECT = 1;
    localparam int unsigned IRQ_START = 2;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

    localparam int unsigned ACK_BIT = 0;

    typedef enum logic [1:0] {
        ST_STANDBY,
        ST_RUNNING,
        ST_TRIPPED,
        ST_REJECTED
    } bfs_state_t;

endpackage

// ===== bfs_pset_mem.sv
// Purpose: Storage for the four parameter sets, two registered reads.
// Assumes: Port a serves the bus, port b serves the active set.
// Notes: Read data appear one clock after the address.
module bfs_pset_mem
    import bfs_pkg::*;
#(
    parameter int unsigned DEPTH = SET_COUNT,
    parameter int unsigned AW = 2
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [31:0] wdata,
    input wire logic [AW-1:0] raddr_a,
    output logic [31:0] rdata_a,
    input wire logic [AW-1:0] raddr_b,
    output logic [31:0] rdata_b
);
    logic [31:0] mem [DEPTH];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem[i] <= SET_RESET;
            rdata_a <= '0;
            rdata_b <= '0;
        end
        else
        begin
            if (we)
                mem[waddr] <= wdata;
            rdata_a <= mem[raddr_a];
            rdata_b <= mem[raddr_b];
        end
    end
endmodule

// ===== bfs_tick.sv
// Purpose: Prescaler that gives a one-cycle tick every DIV clocks.
// Assumes: Single clock pclk, asynchronous active-low reset.
// Notes: The tick is the only time base of the supervision timer.
module bfs_tick
    import bfs_pkg::*;
#(
    parameter int unsigned DIV = TICK_CYCLES
)
(
    input wire logic pclk,
    input wire logic presetn,
    output logic tick
);
    localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } bfs_tick_t;

    bfs_tick_t r;
    bfs_tick_t next_r;

    always_comb
    begin
        next_r = r;
        next_r.tick = (r.cnt == CW'(DIV - 1));
        next_r.cnt = next_r.tick ? '0 : r.cnt + CW'(1);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            r <= '0;
        else
            r <= next_r;
    end

    assign tick = r.tick;
endmodule

// ===== bfs_top.sv
// Purpose: Breaker failure supervision with backup trip and lockout.
// Assumes: All inputs synchronous to pclk; APB slave with one wait state.
// Notes: Current magnitudes and the frequency flag come from outside.
//
// How it works
// - Software picks current, position or combined failure detection.
// - Current method fails when current is not below threshold at expiry.
// - Position method fails when position never showed open by expiry.
// - Combined method fails only with high current and no open position.
// - Off-nominal frequency blocks current; combined works as position.
// - A trigger starts the timer, which runs on after the trigger drops.
// - Timer expiry without a detected opening raises the backup trip.
// - Software picks the neutral-side or the terminal-side current input.
// - Supervision time and threshold come from the active one of four sets.
// - A detected opening per the chosen method stops the timer at once.
// - Opening seen while triggers stay active leads to the rejected state.
// - The rejected state returns to standby once all triggers drop.
// - A lockout latches with the backup trip and holds until acknowledged.
//
// Decided for this implementation: register access over APB and the address map.
module bfs_top
    import bfs_pkg::*;
#(
    parameter int unsigned TRIG_N = 4,
    parameter int unsigned CUR_W = 16,
    parameter int unsigned TICK_DIV = TICK_CYCLES
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [TRIG_N-1:0] trigger,
    input wire logic [CUR_W-1:0] neutral_side_current_input,
    input wire logic [CUR_W-1:0] terminal_side_current_input,
    input wire logic breaker_open,
    input wire logic freq_off_nominal,
    output logic backup_trip,
    output logic lockout,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        bfs_state_t state;
        logic [SET_FIELD_W-1:0] timer;
        logic [1:0] method;
        logic in_sel;
        logic widef_en;
        logic [1:0] active;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic trip;
        logic lockout;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } bfs_regs_t;

    bfs_regs_t r;
    bfs_regs_t next_r;

    logic tick;
    logic [31:0] set_bus;
    logic [31:0] set_act;
    logic mem_we;

    function automatic logic is_set_addr(input logic [ADDR_W-1:0] a);
        return (a & ADDR_SET_MASK) == ADDR_SET_BASE;
    endfunction

    function automatic logic is_known_addr(input logic [ADDR_W-1:0] a);
        return is_set_addr(a) || a == ADDR_CTRL || a == ADDR_ACTIVE ||
            a == ADDR_STATUS || a == ADDR_IRQ_STAT ||
            a == ADDR_IRQ_MASK || a == ADDR_ACK;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    bfs_tick #(
        .DIV(TICK_DIV)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    bfs_pset_mem #(
        .DEPTH(SET_COUNT),
        .AW(2)
    ) u_mem (
        .pclk(pclk),
        .presetn(presetn),
        .we(mem_we),
        .waddr(paddr[3:2]),
        .wdata(pwdata),
        .raddr_a(paddr[3:2]),
        .rdata_a(set_bus),
        .raddr_b(r.active),
        .rdata_b(set_act)
    );

    ////////////////////////////////////////////////////////////////////////
    // The bus handshake takes the write at the edge where pready is high.
    logic wr_done;
    logic any_trig;
    logic [SET_FIELD_W-1:0] set_time;
    logic [SET_FIELD_W-1:0] set_thr;
    logic [CUR_W-1:0] cur;
    logic cur_low;
    logic opened;

    assign wr_done = psel && penable && r.pready && pwrite;
    assign mem_we = wr_done && is_set_addr(paddr);
    assign any_trig = |trigger;
    assign set_time = set_act[SET_TIME_LSB +: SET_FIELD_W];
    assign set_thr = set_act[SET_THR_LSB +: SET_FIELD_W];
    assign cur = r.in_sel ? terminal_side_current_input
                          : neutral_side_current_input;
    assign cur_low = CUR_W'(set_thr) > cur;

    // Under off-nominal frequency the current measure is not trusted. A
    // blocked current method then never declares failure; the combined
    // method falls back to the position contacts alone.
    always_comb
    begin
        case (r.method)
            METHOD_CURRENT:
                opened = r.widef_en && freq_off_nominal
                    ? 1'b1 : cur_low;
            METHOD_POSITION:
                opened = breaker_open;
            METHOD_COMBINED:
                opened = r.widef_en && freq_off_nominal
                    ? breaker_open
                    : (cur_low || breaker_open);
            default:
                opened = cur_low || breaker_open;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        logic [IRQ_W-1:0] ev;
        ev = '0;
        next_r = r;

        // Supervision sequence; all decisions are taken on a tick.
        case (r.state)
            ST_STANDBY:
                if (tick && any_trig)
                begin
                    next_r.state = ST_RUNNING;
                    next_r.timer = (set_time == '0) ? SET_FIELD_W'(1)
                                                    : set_time;
                    ev[IRQ_START] = 1'b1;
                end
            ST_RUNNING:
                if (tick)
                begin
                    if (opened)
                    begin
                        next_r.state = any_trig ? ST_REJECTED
                                                : ST_STANDBY;
                        ev[IRQ_REJECT] = any_trig;
                    end
                    else if (r.timer <= SET_FIELD_W'(1))
                    begin
                        next_r.state = ST_TRIPPED;
                        next_r.timer = '0;
                        next_r.trip = 1'b1;
                        ev[IRQ_TRIP] = 1'b1;
                    end
                    else
                        next_r.timer = r.timer - SET_FIELD_W'(1);
                end
            ST_TRIPPED:
                // The backup trip stands until every trigger has fallen.
                if (tick && !any_trig)
                begin
                    next_r.state = ST_STANDBY;
                    next_r.trip = 1'b0;
                end
            ST_REJECTED:
                if (tick && !any_trig)
                    next_r.state = ST_STANDBY;
            default:
                next_r.state = ST_STANDBY;
        endcase

        // Register writes.
        if (wr_done)
        begin
            case (paddr)
                ADDR_CTRL:
                begin
                    next_r.method = pwdata[CTRL_METHOD_LSB +: 2];
                    next_r.in_sel = pwdata[CTRL_INSEL_BIT];
                    next_r.widef_en = pwdata[CTRL_WIDEF_BIT];
                end
                ADDR_ACTIVE:
                    next_r.active = pwdata[1:0];
                ADDR_IRQ_STAT:
                    next_r.irq_stat = r.irq_stat & ~pwdata[IRQ_W-1:0];
                ADDR_IRQ_MASK:
                    next_r.irq_mask = pwdata[IRQ_W-1:0];
                ADDR_ACK:
                    if (pwdata[ACK_BIT])
                        next_r.lockout = 1'b0;
                default:
                    next_r.method = next_r.method;
            endcase
        end

        // A new event wins over a clear in the same cycle.
        next_r.irq_stat = next_r.irq_stat | ev;
        if (ev[IRQ_TRIP])
            next_r.lockout = 1'b1;
        next_r.irq = |(next_r.irq_stat & next_r.irq_mask);

        // Bus answer: one wait state, read data from a register.
        next_r.pready = psel && penable && !r.pready;
        next_r.pslverr = next_r.pready && !is_known_addr(paddr);
        next_r.prdata = '0;
        if (next_r.pready && !pwrite)
        begin
            if (is_set_addr(paddr))
                next_r.prdata = set_bus;
            else
            begin
                case (paddr)
                    ADDR_CTRL:
                        next_r.prdata = {28'h0000000, r.widef_en,
                            r.in_sel, r.method};
                    ADDR_ACTIVE:
                        next_r.prdata = {30'h0, r.active};
                    ADDR_STATUS:
                        next_r.prdata = {r.timer, 12'h000, r.lockout,
                            r.trip, r.state};
                    ADDR_IRQ_STAT:
                        next_r.prdata = {29'h0, r.irq_stat};
                    ADDR_IRQ_MASK:
                        next_r.prdata = {29'h0, r.irq_mask};
                    default:
                        next_r.prdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= '0;
            r.state <= ST_STANDBY;
            r.method <= CTRL_METHOD_RESET;
            r.in_sel <= CTRL_INSEL_RESET;
            r.widef_en <= CTRL_WIDEF_RESET;
            r.active <= ACTIVE_RESET;
            r.irq_mask <= IRQ_MASK_RESET;
        end
        else
            r <= next_r;
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign backup_trip = r.trip;
    assign lockout = r.lockout;
    assign irq = r.irq;

    ////////////////////////////////////////////////////////////////////////
    chk_trip_sets_lock: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(r.trip) |-> r.lockout)
        else $error("Lockout not raised with backup trip.");

    chk_lock_holds: assert property (
        @(posedge pclk) disable iff (!presetn)
        r.lockout && !(wr_done && paddr == ADDR_ACK && pwdata[ACK_BIT])
        |=> r.lockout)
        else $error("Lockout dropped without acknowledge.");

    chk_trig_starts: assert property (
        @(posedge pclk) disable iff (!presetn)
        r.state == ST_STANDBY && tick && any_trig
        |=> r.state == ST_RUNNING && r.timer != '0)
        else $error("Trigger did not start supervision.");

    chk_idle_between: assert property (
        @(posedge pclk) disable iff (!presetn)
        r.state == ST_RUNNING && !tick
        |=> r.state == ST_RUNNING && $stable(r.timer))
        else $error("Timer moved between ticks.");

    chk_no_restart: assert property (
        @(posedge pclk) disable iff (!presetn)
        r.state == ST_RUNNING && tick && !opened && r.timer > 1
        |=> r.state == ST_RUNNING && r.timer == $past(r.timer) - 1)
        else $error("Timer restarted or failed to count.");

    chk_expiry_trips: assert property (
        @(posedge pclk) disable iff (!presetn)
        r.state == ST_RUNNING && tick && !opened && r.timer == 1
        |=> r.trip && r.state == ST_TRIPPED)
        else $error("Expiry without opening gave no backup trip.");

    chk_open_stops: assert property (
        @(posedge pclk) disable iff (!presetn)
        r.state == ST_RUNNING && tick && opened
        |=> !r.trip && $stable(r.timer) &&
            r.state == ($past(any_trig) ? ST_REJECTED : ST_STANDBY))
        else $error("Detected opening did not stop the timer.");

    chk_reject_holds: assert property (
        @(posedge pclk) disable iff (!presetn)
        r.state == ST_REJECTED && any_trig |=> r.state == ST_REJECTED)
        else $error("Rejected state left while a trigger stands.");

    chk_reject_exit: assert property (
        @(posedge pclk) disable iff (!presetn)
        r.state == ST_REJECTED && tick && !any_trig
        |=> r.state == ST_STANDBY)
        else $error("Rejected state did not return to standby.");

    chk_trip_holds: assert property (
        @(posedge pclk) disable iff (!presetn)
        r.trip && any_trig |=> r.trip)
        else $error("Backup trip dropped while a trigger stands.");

    chk_wide_combined: assert property (
        @(posedge pclk) disable iff (!presetn)
        r.widef_en && freq_off_nominal && r.method == METHOD_COMBINED
        |-> opened == breaker_open)
        else $error("Combined method not reduced to position check.");

    chk_blocked_current: assert property (
        @(posedge pclk) disable iff (!presetn)
        r.state == ST_RUNNING && tick && r.widef_en && freq_off_nominal &&
        r.method == METHOD_CURRENT |=> r.state != ST_TRIPPED)
        else $error("Blocked current method raised a backup trip.");

    chk_irq_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        ##1 irq == |(r.irq_stat & r.irq_mask))
        else $error("Interrupt output disagrees with status and mask.");
endmodule

// ===== bfs_top_tb.sv
// Purpose: Self-checking bench for the breaker failure supervision block.
// Assumes: APB master tasks; the breaker model feeds the terminal current.
// Notes: A short tick divider keeps the supervision times small.
module bfs_top_tb;
    import bfs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int DIV = 4;
    localparam int TT = 3;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] trigger = 4'h0;
    logic [15:0] neutral = 16'h0200;
    logic [15:0] terminal;
    logic breaker_open;
    logic freq_off_nominal = 1'b0;
    logic backup_trip;
    logic lockout;
    logic irq;
    logic pos_works = 1'b0;
    logic cur_works = 1'b0;
    logic [31:0] rd;
    logic err;
    logic in_time;
    int n_fail = 0;
    int compares = 0;
    int total;

    always #5 pclk = ~pclk;

    bfs_top #(.TRIG_N(4), .CUR_W(16), .TICK_DIV(DIV)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .trigger(trigger),
        .neutral_side_current_input(neutral),
        .terminal_side_current_input(terminal),
        .breaker_open(breaker_open), .freq_off_nominal(freq_off_nominal),
        .backup_trip(backup_trip), .lockout(lockout), .irq(irq));

    bfs_breaker_model brk (
        .pclk(pclk), .presetn(presetn), .trip_cmd(|trigger),
        .pos_works(pos_works), .cur_works(cur_works),
        .load_current(16'h0200), .breaker_open(breaker_open),
        .current(terminal));

    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; read data and error are taken at the pready edge.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (i == 20)
        begin
            n_fail++;
            report_and_stop();
        end
        else
        begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    task automatic wait_trip(output int n);
        for (n = 0; n < (TT + 2) * DIV + 4; n++)
        begin
            @(posedge pclk);
            if (backup_trip === 1'b1)
                break;
        end
    endtask

    // Trigger held until expiry has passed, then dropped.
    task automatic run_case(input logic [1:0] m, input logic wf,
                            input logic fq, input logic sel, input logic pw,
                            input logic cw, input logic [15:0] nv,
                            input logic exp);
        int n;
        apb(1'b1, ADDR_CTRL, {28'h0, wf, sel, m});
        freq_off_nominal <= fq;
        pos_works <= pw;
        cur_works <= cw;
        neutral <= nv;
        @(posedge pclk);
        trigger <= 4'h2;
        wait_trip(n);
        check(backup_trip, exp);
        check(lockout, exp);
        if (!exp)
        begin
            apb(1'b0, ADDR_STATUS, 32'h0);
            check(rd & 32'h3, 32'h3);
        end
        trigger <= 4'h0;
        repeat (3 * DIV) @(posedge pclk);
        check(backup_trip, 1'b0);
        // A stopped timer keeps what was left; only a trip empties it.
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(rd & 32'hffff, {28'h0, exp, 3'h0});
        check(rd[31:16] == 16'h0, exp);
        rd_chk(ADDR_IRQ_STAT, {29'h0, 1'b1, !exp, exp});
        apb(1'b1, ADDR_ACK, 32'h1);
        apb(1'b1, ADDR_IRQ_STAT, 32'h7);
        repeat (2) @(posedge pclk);
        check(lockout, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (100000) @(posedge pclk);
        n_fail++;
        report_and_stop();
    end

    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(ADDR_CTRL, {28'h0, CTRL_WIDEF_RESET, CTRL_INSEL_RESET,
                           CTRL_METHOD_RESET});
        for (int s = 0; s < SET_COUNT; s++)
            rd_chk(ADDR_SET_BASE + 8'(4 * s), SET_RESET);
        rd_chk(ADDR_ACTIVE, {30'h0, ACTIVE_RESET});
        rd_chk(ADDR_IRQ_MASK, {29'h0, IRQ_MASK_RESET});
        rd_chk(ADDR_STATUS, 32'h0);
        rd_chk(ADDR_ACK, 32'h0);
        apb(1'b1, 8'h18, 32'hffff_ffff);
        check(err, 1'b1);
        rd_chk(8'h18, 32'h0);
        check(err, 1'b1);
        // Set 0 keeps a 100-tick time, so only set 1 trips in time.
        apb(1'b1, ADDR_SET_BASE + 8'h04, 32'h0180_0003);
        apb(1'b1, ADDR_ACTIVE, 32'h1);
        @(posedge pclk);
        trigger <= 4'h1;
        repeat (2 * DIV) @(posedge pclk);
        trigger <= 4'h0;
        repeat (DIV) @(posedge pclk);
        trigger <= 4'h8;
        wait_trip(total);
        total = total + 3 * DIV;
        check(backup_trip, 1'b1);
        in_time = total >= TT * DIV && total <= (TT + 1) * DIV + 2;
        check(in_time, 1'b1);
        check(lockout, 1'b1);
        check(irq, 1'b0);
        trigger <= 4'h0;
        repeat (3 * DIV) @(posedge pclk);
        check(backup_trip, 1'b0);
        check(lockout, 1'b1);
        rd_chk(ADDR_IRQ_STAT, 32'h5);
        apb(1'b1, ADDR_IRQ_MASK, 32'h7);
        repeat (2) @(posedge pclk);
        check(irq, 1'b1);
        apb(1'b1, ADDR_IRQ_STAT, 32'h5);
        repeat (2) @(posedge pclk);
        check(irq, 1'b0);
        apb(1'b1, ADDR_ACK, 32'h1);
        repeat (2) @(posedge pclk);
        check(lockout, 1'b0);
        run_case(METHOD_CURRENT, 0, 0, 1, 1, 0, 16'h0200, 1);
        run_case(METHOD_CURRENT, 0, 0, 1, 0, 1, 16'h0200, 0);
        run_case(METHOD_POSITION, 0, 0, 1, 0, 1, 16'h0200, 1);
        run_case(METHOD_POSITION, 0, 0, 1, 1, 0, 16'h0200, 0);
        run_case(METHOD_COMBINED, 0, 0, 1, 1, 0, 16'h0200, 0);
        run_case(METHOD_COMBINED, 0, 0, 1, 0, 1, 16'h0200, 0);
        run_case(METHOD_COMBINED, 0, 0, 1, 0, 0, 16'h0200, 1);
        run_case(METHOD_COMBINED, 1, 1, 1, 0, 1, 16'h0200, 1);
        run_case(METHOD_COMBINED, 1, 0, 1, 0, 1, 16'h0200, 0);
        run_case(METHOD_CURRENT, 1, 1, 1, 0, 0, 16'h0200, 0);
        run_case(METHOD_CURRENT, 0, 0, 0, 0, 0, 16'h0000, 0);
        run_case(METHOD_CURRENT, 0, 0, 0, 0, 1, 16'h0200, 1);
        report_and_stop();
    end
endmodule
